// *** logic/iprp_builder.sv ***
/*
 Interleaved parity repair packet builder. Source packets are passed on
 untouched elsewhere; this block sees a copy of each one: its header
 summary on hdr_* and its protected body (csrc list, extension, payload,
 padding) as words on body_*. After D rows of L columns, one repair packet
 per column is emitted on the repair stream, header words first.
 Assumes: cols/rows stable while enabled; bodies at most
 IPRP_COL_BUF_WORDS words; hdr for a packet arrives before its body.
*/
// Contract
// R1: Source packets stay untouched; only their sequence numbers identify them.
// R2: One repair packet per column, over that column's D packets.
// R3: Repair version field is always 2.
// R4: Padding bit is XOR of source padding bits; no padding octets.
// R5: Extension bit is XOR of source bits; no header extension.
// R6: CSRC count is XOR of source counts; no CSRC list.
// R7: Marker bit is XOR of source marker bits.
// R8: Receivers not knowing the repair payload type discard repair packets.
// R9: Repair sequence number increments by one; start is unpredictable. Code starts at IPRP_SEQ_RESET (0) unless seq_seed_in is loaded.
// R10: Repair timestamp reflects its transmission time.
// R11: Repair SSRC random; collisions resolved by standard RTP procedure.
// R12: Separate source and repair hosts share one canonical name.
// R13: Parity covers CSRC list, extension, payload and padding present.
// R14: A 16-octet FEC header follows the RTP header.
// R15: Base sequence is the lowest protected sequence, wrap-aware.
// R16: FEC header carries length, payload type and timestamp recovery.
// R17: Offset field holds column count, row-count field holds rows.
// R18: Extension flag set; second flag reserved; unused fields meaningless.
// R19: Code type field names the interleaved parity code.
// R20: Column and row counts are 1 to 255.
// R21: Repair timestamp rate exceeds 1000 Hz, ideally source rate.
// R22: Decoder waits no longer than the repair window.
// R23: Meaningless FEC header fields are driven zero.
module iprp_builder #(
   parameter int COLS_MAX = iprp_pkg::IPRP_MAX_COLS,
   parameter int BUF_WORDS = iprp_pkg::IPRP_COL_BUF_WORDS
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic sys_rst_in,
   // Configuration
   input wire logic enable_in,
   input wire iprp_pkg::iprp_cfg_t cfg_in,
   input wire logic [31:0] ssrc_in,
   input wire logic [15:0] seq_seed_in,
   input wire logic seq_seed_load_in,
   input wire logic [31:0] media_time_in,
   // Source header summary
   input wire logic hdr_valid_in,
   input wire iprp_pkg::iprp_src_hdr_t hdr_in,
   output logic hdr_ready_out,
   // Source body words
   input wire logic body_valid_in,
   input wire iprp_pkg::iprp_word_t body_in,
   output logic body_ready_out,
   // Repair stream
   output logic rep_valid_out,
   output iprp_pkg::iprp_word_t rep_out,
   input wire logic rep_ready_in,
   // Status
   output logic busy_out,
   output logic cfg_error_out
);
   import iprp_pkg::*;

   typedef enum logic [1:0] {IPRP_ACCUM, IPRP_HDR, IPRP_BODY} iprp_state_t;

   localparam int AW = $clog2(BUF_WORDS);
   localparam int CW = $clog2(COLS_MAX);

   // Wrap-aware "a before b" on 16-bit sequence numbers
   function automatic logic seq_before(input logic [15:0] a, input logic [15:0] b);
      logic [15:0] diff;
      diff = b - a;
      seq_before = (diff != 16'h0000) && !diff[15];
   endfunction

   iprp_src_hdr_t col_hdr_q [COLS_MAX];
   logic [15:0] col_base_q [COLS_MAX];
   logic [15:0] col_len_q [COLS_MAX];
   logic [IPRP_WORD_W-1:0] par_mem [COLS_MAX*BUF_WORDS];

   iprp_state_t state_q, state_d;
   logic [CW-1:0] col_q, col_d;
   logic [7:0] row_q, row_d;
   logic [AW-1:0] wptr_q, wptr_d;
   logic [AW:0] optr_q, optr_d;
   logic [2:0] hword_q, hword_d;
   logic [15:0] rseq_q, rseq_d;
   logic [31:0] stamp_q;
   logic in_pkt_q, in_pkt_d;

   // Two-entry skid buffer on the repair output
   iprp_word_t sk_q [2];
   logic [1:0] sk_cnt_q, sk_cnt_d;
   logic push, pop;
   iprp_word_t push_word;

   logic cfg_ok;
   logic first_row;
   logic hdr_take, body_take;
   logic [AW+CW-1:0] waddr, raddr;
   logic [IPRP_WORD_W-1:0] par_rd;
   iprp_src_hdr_t h;
   logic [CW-1:0] last_col;

   // R20: count limits
   assign cfg_ok = (cfg_in.cols != 8'h00) && (cfg_in.rows != 8'h00)
      && (int'(cfg_in.cols) <= COLS_MAX);
   assign cfg_error_out = enable_in && !cfg_ok;
   assign last_col = CW'(cfg_in.cols - 8'h01);
   assign first_row = (row_q == 8'h00);

   // R1: copies only are consumed, nothing is forwarded or altered
   assign hdr_ready_out = (state_q == IPRP_ACCUM) && enable_in && cfg_ok && !in_pkt_q;
   assign body_ready_out = (state_q == IPRP_ACCUM) && in_pkt_q;
   assign hdr_take = hdr_valid_in && hdr_ready_out;
   assign body_take = body_valid_in && body_ready_out;
   assign busy_out = (state_q != IPRP_ACCUM);

   assign waddr = {col_q, wptr_q};
   assign raddr = {col_q, optr_q[AW-1:0]};
   assign par_rd = par_mem[raddr];
   assign h = col_hdr_q[col_q];

   assign pop = rep_ready_in && (sk_cnt_q != 2'h0);
   assign rep_valid_out = (sk_cnt_q != 2'h0);
   assign rep_out = sk_q[0];

   always_comb begin
      state_d = state_q;
      col_d = col_q;
      row_d = row_q;
      wptr_d = wptr_q;
      optr_d = optr_q;
      hword_d = hword_q;
      rseq_d = rseq_q;
      in_pkt_d = in_pkt_q;
      push = 1'b0;
      push_word = '0;
      case (state_q)
         IPRP_ACCUM: begin
            if (hdr_take) begin
               in_pkt_d = 1'b1;
               wptr_d = '0;
            end
            if (body_take) begin
               wptr_d = wptr_q + AW'(1);
               if (body_in.last) begin
                  in_pkt_d = 1'b0;
                  // R2: next packet falls in the next column
                  if (col_q == last_col) begin
                     col_d = '0;
                     if (row_q == cfg_in.rows - 8'h01) begin
                        row_d = 8'h00;
                        state_d = IPRP_HDR;
                        hword_d = '0;
                     end else begin
                        row_d = row_q + 8'h01;
                     end
                  end else begin
                     col_d = col_q + CW'(1);
                  end
               end
            end
         end
         IPRP_HDR: begin
            if (sk_cnt_q != 2'h2 && !(sk_cnt_q == 2'h1 && !pop)) begin
               push = 1'b1;
               case (hword_q)
                  // R3: version; R4 R5 R6 R7: XOR-protected bits, no lists follow
                  3'h0: push_word.data = {IPRP_RTP_VERSION, h.pad, h.ext, h.csrc_cnt,
                     h.marker, cfg_in.payload_kind, rseq_q};
                  // R10: stamp taken at transmission
                  3'h1: push_word.data = stamp_q;
                  // R11 R12: identifier and name owned by the host stack
                  3'h2: push_word.data = ssrc_in;
                  // R14 R15 R16: FEC header, base and length recovery
                  3'h3: push_word.data = {col_base_q[col_q], col_len_q[col_q]};
                  // R18 R19 R23: ext flag set, mask zero; R16 payload kind
                  3'h4: push_word.data = {IPRP_EXT_FLAG, h.payload_kind, 24'h000000};
                  3'h5: push_word.data = h.stamp;
                  // R17 R19 R23: type, offset and row count, unused zero
                  3'h6: push_word.data = {1'b0, 1'b0, IPRP_CODE_TYPE, 3'h0,
                     cfg_in.cols, cfg_in.rows, 8'h00};
                  default: push_word.data = '0;
               endcase
               hword_d = hword_q + 3'h1;
               if (hword_q == 3'(IPRP_HDR_WORDS - 1)) begin
                  state_d = IPRP_BODY;
                  optr_d = '0;
               end
            end
         end
         IPRP_BODY: begin
            if (sk_cnt_q != 2'h2 && !(sk_cnt_q == 2'h1 && !pop)) begin
               push = 1'b1;
               push_word.data = par_rd;
               optr_d = optr_q + (AW+1)'(1);
               if (optr_q == (AW+1)'(col_len_q[col_q] >> 2) - (AW+1)'(1)
                     || col_len_q[col_q] < 16'h0004) begin
                  push_word.last = 1'b1;
                  // R9: increments per repair packet
                  rseq_d = rseq_q + 16'h0001;
                  hword_d = '0;
                  if (col_q == last_col) begin
                     col_d = '0;
                     state_d = IPRP_ACCUM;
                  end else begin
                     col_d = col_q + CW'(1);
                     state_d = IPRP_HDR;
                  end
               end
            end
         end
         default: state_d = IPRP_ACCUM;
      endcase
      if (seq_seed_load_in) begin
         rseq_d = seq_seed_in;
      end
   end

   always_comb begin
      sk_cnt_d = sk_cnt_q + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_q <= IPRP_ACCUM;
         col_q <= '0;
         row_q <= 8'h00;
         wptr_q <= '0;
         optr_q <= '0;
         hword_q <= '0;
         rseq_q <= IPRP_SEQ_RESET;
         in_pkt_q <= 1'b0;
         sk_cnt_q <= 2'h0;
         stamp_q <= 32'h00000000;
      end else begin
         state_q <= state_d;
         col_q <= col_d;
         row_q <= row_d;
         wptr_q <= wptr_d;
         optr_q <= optr_d;
         hword_q <= hword_d;
         rseq_q <= rseq_d;
         in_pkt_q <= in_pkt_d;
         sk_cnt_q <= sk_cnt_d;
         // R10 R21: host media clock, latched as the header starts
         if (state_q != IPRP_HDR && state_d == IPRP_HDR) begin
            stamp_q <= media_time_in;
         end
      end
   end

   // Skid storage; data only, occupancy is reset above
   always_ff @(posedge clock_in) begin
      if (pop) begin
         sk_q[0] <= (sk_cnt_q == 2'h2) ? sk_q[1] : push_word;
      end else if (push && sk_cnt_q == 2'h0) begin
         sk_q[0] <= push_word;
      end
      if (push && (sk_cnt_q == 2'h1) && !pop) begin
         sk_q[1] <= push_word;
      end
   end

   // Column accumulators; first row loads, later rows XOR, except the base, which keeps the minimum
   always_ff @(posedge clock_in) begin
      if (hdr_take) begin
         if (first_row) begin
            col_hdr_q[col_q] <= hdr_in;
            col_base_q[col_q] <= hdr_in.seq;
            col_len_q[col_q] <= hdr_in.length;
         end else begin
            col_hdr_q[col_q] <= col_hdr_q[col_q] ^ hdr_in;
            col_len_q[col_q] <= col_len_q[col_q] ^ hdr_in.length;
            // R15: wrap-aware minimum
            if (seq_before(hdr_in.seq, col_base_q[col_q])) begin
               col_base_q[col_q] <= hdr_in.seq;
            end
         end
      end
      // R13: parity over every body word present
      if (body_take) begin
         par_mem[waddr] <= (first_row ? '0 : par_mem[waddr]) ^ body_in.data;
      end
   end
endmodule

// *** inc/iprp_pkg.sv ***
/*
 Package for the interleaved parity repair packet builder: header field
 constants, configuration and header structs.
 Assumes one synchronous clock domain and 32-bit word streams.
*/
package iprp_pkg;
   localparam int IPRP_WORD_W = 32;
   localparam int IPRP_MAX_COLS = 255;
   localparam int IPRP_MAX_ROWS = 255;
   localparam logic [1:0] IPRP_RTP_VERSION = 2'h2;
   localparam logic [2:0] IPRP_CODE_TYPE = 3'h0;
   localparam logic IPRP_EXT_FLAG = 1'h1;
   localparam int IPRP_RTP_HDR_WORDS = 3;
   localparam int IPRP_FEC_HDR_WORDS = 4;
   localparam int IPRP_HDR_WORDS = IPRP_RTP_HDR_WORDS + IPRP_FEC_HDR_WORDS;
   localparam logic [15:0] IPRP_SEQ_RESET = 16'h0000;
   localparam logic [31:0] IPRP_LFSR_SEED = 32'h1d2c3b4a;
   localparam int IPRP_COL_BUF_WORDS = 1024;

   typedef struct packed {
      logic [6:0] payload_kind;
      logic [7:0] cols;
      logic [7:0] rows;
   } iprp_cfg_t;

   // Per-source-packet header summary, XOR-accumulated per column
   typedef struct packed {
      logic pad;
      logic ext;
      logic [3:0] csrc_cnt;
      logic marker;
      logic [6:0] payload_kind;
      logic [15:0] seq;
      logic [31:0] stamp;
      logic [15:0] length;
   } iprp_src_hdr_t;

   typedef struct packed {
      logic [IPRP_WORD_W-1:0] data;
      logic last;
   } iprp_word_t;
endpackage

// *** sim/iprp_chk.sv ***
/* Repair word layout and handshake checker.
   Assumes binding to the builder, seeing its ports only. */
module iprp_chk (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic [15:0] seq_seed_in,
   input wire logic seq_seed_load_in,
   input wire iprp_pkg::iprp_cfg_t cfg_in,
   input wire logic [31:0] ssrc_in,
   input wire logic hdr_ready_out,
   input wire logic busy_out,
   input wire logic rep_valid_out,
   input wire logic rep_ready_in,
   input wire iprp_pkg::iprp_word_t rep_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import iprp_pkg::*;
   logic [3:0] idx_q;
   logic [15:0] seq_q;
   logic tk;
   logic [31:0] w;
   logic v0;
   assign tk = rep_valid_out && rep_ready_in;
   assign w = rep_out.data;
   assign v0 = rep_valid_out && idx_q == 4'h0;
   // Saturates so a runaway packet cannot wrap into header slots
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         idx_q <= 4'h0;
         seq_q <= IPRP_SEQ_RESET;
      end else begin
         if (tk) idx_q <= rep_out.last ? 4'h0 : idx_q + {3'h0, idx_q != 4'hf};
         if (seq_seed_load_in) seq_q <= seq_seed_in;
         else if (tk && idx_q == 4'h0) seq_q <= seq_q + 16'h1;
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   chk_stall_hold:
      assert property (rep_valid_out && !rep_ready_in |=> rep_valid_out && $stable(rep_out))
      else $error("stalled word changed");
   chk_ver_field:
      assert property (v0 |-> w[31:30] == IPRP_RTP_VERSION && w[22:16] == cfg_in.payload_kind)
      else $error("bad first word");
   chk_seq_step:
      assert property (v0 |-> w[15:0] == seq_q) else $error("sequence gap");
   chk_ssrc_word:
      assert property (rep_valid_out && idx_q == 4'h2 |-> w == ssrc_in) else $error("bad ssrc");
   chk_hdr_len:
      assert property (rep_valid_out && idx_q < 4'h7 |-> !rep_out.last) else $error("short hdr");
   chk_ext_flag:
      assert property (rep_valid_out && idx_q == 4'h4 |-> w[31] && w[23:0] == 24'h0)
      else $error("bad fec word 4");
   chk_block_dims:
      assert property (rep_valid_out && idx_q == 4'h6 |-> w == {2'h0, IPRP_CODE_TYPE, 3'h0,
         cfg_in.cols, cfg_in.rows, 8'h0}) else $error("bad fec word 6");
   chk_busy_refuse:
      assert property (busy_out |-> !hdr_ready_out) else $error("header taken while busy");
   chk_burst_end:
      assert property ($fell(busy_out) |-> rep_valid_out && rep_out.last)
      else $error("burst ended without last word");
endmodule
bind iprp_builder iprp_chk iprp_chk_inst (.*);

// *** sim/iprp_sink.sv ***
/* Receiver model: takes repair words, optionally stalling.
   Assumes the bench decodes the stored words. */
module iprp_sink (
   input wire logic clock_in,
   input wire logic slow_in,
   input wire logic valid_in,
   input wire iprp_pkg::iprp_word_t word_in,
   output logic ready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import iprp_pkg::*;
   iprp_word_t got[$];
   initial begin
      ready_out = 1'b0;
      forever @(negedge clock_in) ready_out <= slow_in ? ~ready_out : 1'b1;
   end
   always @(posedge clock_in) if (valid_in && ready_out) got.push_back(word_in);
endmodule

// *** sim/tb_top.sv ***
/* Bench: two 2x3 blocks (fast, then stalled after a reload), bad configurations,
   then a third block after a mid-block reset. Assumes the sink model and the bound checker. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import iprp_pkg::*;
   logic clock_in = 0, sys_rst_in = 1, en = 0, ld = 0, hv = 0, bv = 0, slow = 0;
   iprp_cfg_t cfg = '{7'h60, 8'h2, 8'h3};
   iprp_src_hdr_t hdr = '0;
   iprp_word_t body = '0, rep, g;
   logic [15:0] seed = 16'hfffe;
   logic hr, br, rv, rr, busy, cerr;
   int mismatches = 0, n_tests = 0;
   iprp_src_hdr_t h[6], a;
   logic [31:0] b[6][2], x[9];
   // Rows: expected error flag, then cols and rows
   logic [16:0] bad[4] = '{17'h10003, 17'h10200, 17'h10503, 17'h00203};
   logic [31:0] mt = 32'h00c0ffee;
   iprp_builder #(.COLS_MAX(4), .BUF_WORDS(16)) iprp_builder_inst (.clock_in(clock_in),
      .sys_rst_in(sys_rst_in), .enable_in(en), .cfg_in(cfg), .ssrc_in(32'h5a5a1234),
      .seq_seed_in(seed), .seq_seed_load_in(ld), .media_time_in(mt),
      .hdr_valid_in(hv), .hdr_in(hdr), .hdr_ready_out(hr), .body_valid_in(bv),
      .body_in(body), .body_ready_out(br), .rep_valid_out(rv), .rep_out(rep),
      .rep_ready_in(rr), .busy_out(busy), .cfg_error_out(cerr));
   iprp_sink iprp_sink_inst (.clock_in(clock_in), .slow_in(slow), .valid_in(rv),
      .word_in(rep), .ready_out(rr));
   initial forever #5 clock_in = ~clock_in;
   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic send(int i);
      @(negedge clock_in);
      hdr = h[i];
      hv = 1;
      #1;
      for (int k = 0; k < 99 && hr !== 1'b1; k++) #10;
      @(posedge clock_in);
      @(negedge clock_in);
      hv = 0;
      bv = 1;
      for (int j = 0; j < 2; j++) begin
         body = '{b[i][j], j == 1};
         #1;
         for (int k = 0; k < 99 && br !== 1'b1; k++) #10;
         @(posedge clock_in);
         @(negedge clock_in);
      end
      bv = 0;
   endtask
   task automatic run_block(logic [15:0] s0);
      iprp_sink_inst.got.delete();
      for (int i = 0; i < 6; i++) send(i);
      for (int k = 0; k < 900 && iprp_sink_inst.got.size() < 18; k++) @(negedge clock_in);
      chk("count", 18, iprp_sink_inst.got.size());
      for (int c = 0; c < 2; c++) begin
         a = '0;
         x[7] = '0;
         x[8] = '0;
         for (int r = c; r < 6; r += 2) begin
            a = a ^ h[r];
            x[7] ^= b[r][0];
            x[8] ^= b[r][1];
         end
         x[0] = {2'h2, a.pad, a.ext, a.csrc_cnt, a.marker, 7'h60, s0 + 16'(c)};
         x[1] = mt;
         x[2] = 32'h5a5a1234;
         // Column 0 spans the wrap: ffff is lowest
         x[3] = {c ? 16'h0000 : 16'hffff, a.length};
         x[4] = {1'b1, a.payload_kind, 24'h0};
         x[5] = a.stamp;
         x[6] = {8'h0, 8'h2, 8'h3, 8'h0};
         for (int k = 0; k < 9; k++) begin
            g = iprp_sink_inst.got[9 * c + k];
            chk("word", x[k], g.data);
            chk("last", 32'(k == 8), 32'(g.last));
         end
      end
      $display("block done");
   endtask
   task automatic stop_test;
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #100us;
      mismatches++;
      stop_test;
   end
   initial begin
      for (int i = 0; i < 6; i++) begin
         h[i] = '{i[0], i[1], 4'(i + 3), i == 2, 7'(i + 16), 16'hffff + 16'(i),
            32'(i * 256 + 7), 16'h8};
         b[i][0] = 32'h11111111 * 32'(i + 1);
         b[i][1] = 32'ha5000000 ^ 32'(i);
      end
      repeat (4) @(posedge clock_in);
      @(negedge clock_in);
      sys_rst_in = 0;
      en = 1;
      run_block(16'h0000);
      @(negedge clock_in);
      ld = 1;
      slow = 1;
      @(negedge clock_in);
      ld = 0;
      run_block(16'hfffe);
      for (int i = 0; i < 4; i++) begin
         @(negedge clock_in);
         cfg = '{7'h60, bad[i][15:8], bad[i][7:0]};
         @(negedge clock_in);
         chk("cfg_err", 32'(bad[i][16]), 32'(cerr));
      end
      $display("config done");
      // Disabled block flags nothing and takes no header
      @(negedge clock_in);
      en = 0;
      cfg = '{7'h60, 8'h0, 8'h3};
      @(negedge clock_in);
      chk("cfg_err_off", 0, 32'(cerr));
      chk("hdr_ready_off", 0, 32'(hr));
      cfg = '{7'h60, 8'h2, 8'h3};
      en = 1;
      // Reset in mid-block must drop the partial rows
      send(0);
      send(1);
      send(2);
      @(negedge clock_in);
      sys_rst_in = 1;
      repeat (4) @(posedge clock_in);
      @(negedge clock_in);
      sys_rst_in = 0;
      chk("rst_hdr_ready", 1, 32'(hr));
      chk("rst_body_ready", 0, 32'(br));
      chk("rst_busy", 0, 32'(busy));
      chk("rst_valid", 0, 32'(rv));
      $display("reset done");
      mt = 32'h7e570001;
      run_block(16'h0000);
      stop_test;
   end
endmodule
